// ===== rtl/ddc_pkg.sv
// ddc_pkg: constants for the dual dac command control block.
// assumes a 100 MHz system clock and a slow host serial clock.
package ddc_pkg;
	// ----------------------------------------
	// frame layout
	// ----------------------------------------
	localparam int FRAME_BITS = 32;
	localparam int CMD_HI = 27;
	localparam int CMD_LO = 24;
	localparam int ADR_HI = 23;
	localparam int ADR_LO = 20;
	localparam int DATA_HI = 19;
	localparam int DATA_LO = 4;
	localparam int PMODE_HI = 9;
	localparam int PMODE_LO = 8;
	localparam int SEL_B = 3;
	localparam int SEL_A = 0;
	localparam int CHAIN_BIT = 1;
	localparam int CCODE_HI = 1;
	localparam int CCODE_LO = 0;
	// ----------------------------------------
	// command codes
	// ----------------------------------------
	localparam logic [3:0] CMD_WR_IN = 4'h0;
	localparam logic [3:0] CMD_UPD = 4'h1;
	localparam logic [3:0] CMD_WR_UPD_ALL = 4'h2;
	localparam logic [3:0] CMD_WR_UPD = 4'h3;
	localparam logic [3:0] CMD_PWR = 4'h4;
	localparam logic [3:0] CMD_CCODE = 4'h5;
	localparam logic [3:0] CMD_OVR = 4'h6;
	localparam logic [3:0] CMD_RESET = 4'h7;
	localparam logic [3:0] CMD_CHAIN = 4'h8;
	// ----------------------------------------
	// channel addresses
	// ----------------------------------------
	localparam logic [3:0] ADR_A = 4'h0;
	localparam logic [3:0] ADR_B = 4'h3;
	localparam logic [3:0] ADR_BOTH = 4'hF;
	// ----------------------------------------
	// codes
	// ----------------------------------------
	localparam logic [15:0] CODE_ZERO = 16'h0000;
	localparam logic [15:0] CODE_MID = 16'h8000;
	localparam logic [15:0] CODE_FULL = 16'hFFFF;
	localparam logic [1:0] CC_ZERO = 2'h0;
	localparam logic [1:0] CC_MID = 2'h1;
	localparam logic [1:0] CC_FULL = 2'h2;
	localparam logic [1:0] PM_NORMAL = 2'h0;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int WAKE_NS = 4500;
	localparam int CLR_NS = 10600;
	localparam int WAKE_CYC = WAKE_NS * CLK_MHZ / 1000;
	localparam int CLR_CYC = CLR_NS * CLK_MHZ / 1000;
	// level pin needs its three flops plus one cycle before it is trusted
	localparam int POR_SETTLE = 4;
endpackage

// ===== rtl/ddc_sync.sv
// ddc_sync: three-stage synchroniser with agreement-based edge detect.
// assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module ddc_sync (
	input wire logic clk,
	input wire logic srst,
	input wire logic rst_val,
	input wire logic async_in,
	output logic level,
	output logic rise,
	output logic fall
);
	// ----------------------------------------
	// sync chain
	// ----------------------------------------
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic lvl_reg;
	// s1 feeds only s2; a change counts once s2 and s3 agree
	always_ff @(posedge clk) begin
		if (srst) begin
			// idle level of the pin, so no false edge follows reset
			s1_reg <= rst_val;
			s2_reg <= rst_val;
			s3_reg <= rst_val;
			lvl_reg <= rst_val;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				lvl_reg <= s3_reg;
			end
		end
	end
	// reset value chosen by parent, held until first agreement
	wire agree = (s2_reg == s3_reg);
	assign level = agree ? s3_reg : lvl_reg;
	assign rise = agree & s3_reg & ~lvl_reg;
	assign fall = agree & ~s3_reg & lvl_reg;
endmodule
`default_nettype wire

// ===== rtl/ddc_top.sv
// ddc_top: command decoder and register control of a dual dac.
// assumes host serial clock far below 100 MHz; all pins pass ddc_sync.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - frame: 4 ignored, cmd, addr, data
// - address 0 A, 3 B, F both
// - shift on falling clock, execute at 32
// - early frame end discards partial frame
// - command 8 sets chain enable bit
// - power-up code from reset-level pin
// - reset level held until valid write
// - command 7 software reset to pin level
// - command 4 sets power mode
// - mode 00 normal, others power-down
// - bits 3 and 0 select channels
// - power-down keeps dac registers
// - wake-up delays output valid by 4.5 us
// - wake output from input or dac register
// - clear falling edge loads clear code
// - clear code map, default zero
// - command 5 writes clear code
// - next valid write leaves clear; clear aborts frame
// - clear output delayed 10.6 us
// - load pin low updates at 32nd edge
// - load pin fall copies input registers
// - command 2 writes then updates all
// - override bit makes load seen low
module ddc_top #(
	parameter int WAKE_CYCLES = ddc_pkg::WAKE_CYC,
	parameter int CLR_CYCLES = ddc_pkg::CLR_CYC
) (
	input wire logic SYS_CLK,
	input wire logic SRST,
	input wire logic SERIAL_CLK,
	input wire logic FRAME_SEL_N,
	input wire logic SERIAL_DATA,
	input wire logic LOAD_UPDATE_PIN_N,
	input wire logic ASYNC_CLEAR_INPUT_N,
	input wire logic RESET_LEVEL_SEL,
	output logic [15:0] OUT_CODE_A,
	output logic [15:0] OUT_CODE_B,
	output logic [1:0] POWER_MODE_A,
	output logic [1:0] POWER_MODE_B,
	output logic OUT_VALID_A,
	output logic OUT_VALID_B,
	output logic CHAIN_ENABLE,
	output logic CLEAR_ACTIVE
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic sclk_fall, frm_n, frm_rise, ld_n, ld_fall, clr_fall, din, por_lvl;
	// reset values match each pin's idle level, save the level pin, so
	// no false edge shows in the first cycles after reset
	// serial clock parks high; only its fall is used
	ddc_sync u_sclk (.clk(SYS_CLK), .srst(SRST), .rst_val(1'b1), .async_in(SERIAL_CLK),
		.level(), .rise(), .fall(sclk_fall));
	// frame select idles high between frames
	ddc_sync u_frm (.clk(SYS_CLK), .srst(SRST), .rst_val(1'b1), .async_in(FRAME_SEL_N),
		.level(frm_n), .rise(frm_rise), .fall());
	// data shares the clock's delay, so bit and edge line up
	ddc_sync u_din (.clk(SYS_CLK), .srst(SRST), .rst_val(1'b0), .async_in(SERIAL_DATA),
		.level(din), .rise(), .fall());
	// load pin idles high
	ddc_sync u_ld (.clk(SYS_CLK), .srst(SRST), .rst_val(1'b1), .async_in(LOAD_UPDATE_PIN_N),
		.level(ld_n), .rise(), .fall(ld_fall));
	// clear pin idles high
	ddc_sync u_clr (.clk(SYS_CLK), .srst(SRST), .rst_val(1'b1), .async_in(ASYNC_CLEAR_INPUT_N),
		.level(), .rise(), .fall(clr_fall));
	// level pin is static; its value is unknown until synced
	ddc_sync u_por (.clk(SYS_CLK), .srst(SRST), .rst_val(1'b0), .async_in(RESET_LEVEL_SEL),
		.level(por_lvl), .rise(), .fall());

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [31:0] shift_reg; // serial shift register
	logic [5:0] cnt_reg; // falling edges seen
	logic [15:0] in_reg [2]; // input registers, index 0 = A
	logic [15:0] dac_reg [2]; // dac registers
	logic [15:0] out_reg [2]; // delayed output codes
	logic [1:0] pm_reg [2]; // power modes
	logic [1:0] ovr_reg; // load override mask
	logic [1:0] cc_reg; // clear code select
	logic chain_reg; // chain enable
	logic clr_reg; // in clear state
	logic [1:0] vld_reg; // output valid per channel
	logic [31:0] wake_cnt_reg [2]; // wake-up timers
	logic [31:0] clr_cnt_reg; // clear activation timer
	logic [2:0] por_cnt_reg; // cycles left to reload the reset level

	// ----------------------------------------
	// frame decode
	// ----------------------------------------
	// shift on falling edge while frame low
	wire shift_en = sclk_fall & ~frm_n;
	// frame as it stands after this shift
	wire [31:0] frame = {shift_reg[30:0], din};
	wire exec = shift_en & (cnt_reg == 6'(ddc_pkg::FRAME_BITS - 1)) & ~clr_fall;
	wire [3:0] cmd = frame[ddc_pkg::CMD_HI:ddc_pkg::CMD_LO];
	wire [3:0] adr = frame[ddc_pkg::ADR_HI:ddc_pkg::ADR_LO];
	wire [15:0] data = frame[ddc_pkg::DATA_HI:ddc_pkg::DATA_LO];
	wire [1:0] pmode = frame[ddc_pkg::PMODE_HI:ddc_pkg::PMODE_LO];
	wire [1:0] selmask = {frame[ddc_pkg::SEL_B], frame[ddc_pkg::SEL_A]};
	wire [1:0] ccnew = frame[ddc_pkg::CCODE_HI:ddc_pkg::CCODE_LO];

	// address decode; reserved gives no channel
	function automatic logic [1:0] adr_dec(input logic [3:0] a);
		case (a)
			ddc_pkg::ADR_A: adr_dec = 2'h1;
			ddc_pkg::ADR_B: adr_dec = 2'h2;
			ddc_pkg::ADR_BOTH: adr_dec = 2'h3;
			default: adr_dec = 2'h0;
		endcase
	endfunction
	function automatic logic [15:0] cc_dec(input logic [1:0] c);
		case (c)
			ddc_pkg::CC_ZERO: cc_dec = ddc_pkg::CODE_ZERO;
			ddc_pkg::CC_MID: cc_dec = ddc_pkg::CODE_MID;
			default: cc_dec = ddc_pkg::CODE_FULL;
		endcase
	endfunction

	wire [1:0] ach = adr_dec(adr);
	// reserved address means no channel touched
	wire adr_ok = (ach != 2'h0);
	wire do_wr = exec & adr_ok & ((cmd == ddc_pkg::CMD_WR_IN) | (cmd == ddc_pkg::CMD_WR_UPD)
		| (cmd == ddc_pkg::CMD_WR_UPD_ALL));
	wire do_upd_n = exec & adr_ok & ((cmd == ddc_pkg::CMD_UPD) | (cmd == ddc_pkg::CMD_WR_UPD));
	wire do_upd_all = exec & adr_ok & (cmd == ddc_pkg::CMD_WR_UPD_ALL);
	// power, clear code, override, reset and chain ignore the address
	wire do_pwr = exec & (cmd == ddc_pkg::CMD_PWR);
	wire do_cc = exec & (cmd == ddc_pkg::CMD_CCODE);
	wire do_ovr = exec & (cmd == ddc_pkg::CMD_OVR);
	wire do_rst = exec & (cmd == ddc_pkg::CMD_RESET);
	wire do_chain = exec & (cmd == ddc_pkg::CMD_CHAIN);
	// any recognised, well-addressed frame counts as valid write
	wire valid_wr = do_wr | do_upd_n | do_pwr | do_cc | do_ovr | do_rst | do_chain;
	wire [15:0] por_code = por_lvl ? ddc_pkg::CODE_MID : ddc_pkg::CODE_ZERO;
	// code 11 leaves codes and clear state alone on clear
	wire clr_go = clr_fall & (cc_reg != 2'h3);
	// reload until the level pin has crossed its sync chain
	wire por_pend = (por_cnt_reg != 3'h0);

	// ----------------------------------------
	// shift register and bit counter
	// ----------------------------------------
	// a clear mid-frame restarts the count, so the frame's rest falls short
	// frame end or clear discards partial frame
	always_ff @(posedge SYS_CLK) begin
		if (SRST | frm_rise | clr_fall | frm_n) begin
			shift_reg <= 32'h0000_0000;
			cnt_reg <= 6'h00;
		end else if (shift_en) begin
			shift_reg <= frame;
			cnt_reg <= (cnt_reg == 6'(ddc_pkg::FRAME_BITS - 1)) ? 6'h00 : cnt_reg + 6'h01;
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			chain_reg <= 1'b0;
			cc_reg <= ddc_pkg::CC_ZERO;
			ovr_reg <= 2'h0;
			clr_reg <= 1'b0;
			por_cnt_reg <= 3'(ddc_pkg::POR_SETTLE);
		end else begin
			if (do_chain) chain_reg <= frame[ddc_pkg::CHAIN_BIT];
			if (do_cc) cc_reg <= ccnew;
			if (do_ovr) ovr_reg <= selmask;
			if (do_rst) begin
				chain_reg <= 1'b0;
				cc_reg <= ddc_pkg::CC_ZERO;
				ovr_reg <= 2'h0;
			end
			// clear wins; left on next complete write
			if (clr_go) clr_reg <= 1'b1;
			else if (valid_wr) clr_reg <= 1'b0;
			// count down while the reset code is reloaded
			if (por_pend) begin
				por_cnt_reg <= por_cnt_reg - 3'h1;
			end
		end
	end

	// ----------------------------------------
	// per-channel data path
	// ----------------------------------------
	// one copy of the data path per channel; index 0 is A
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			// channel addressed by this frame
			wire hit = ach[ch];
			// override makes load pin seen low
			wire ld_low = ~ld_n | ovr_reg[ch];
			// input register takes data of an addressed write
			wire [15:0] in_next = (do_wr & hit) ? data : in_reg[ch];
			wire sync_ld = do_wr & hit & ld_low;
			// load pin fall copies input register
			wire async_ld = ld_fall | (ovr_reg[ch] & do_wr);
			// any load source moves the input into the dac register
			wire upd = do_upd_all | (do_upd_n & hit) | sync_ld | async_ld;
			// power command aimed at this channel
			wire pm_hit = do_pwr & selmask[ch];
			wire waking = pm_hit & (pmode == ddc_pkg::PM_NORMAL) & (pm_reg[ch] != ddc_pkg::PM_NORMAL);
			always_ff @(posedge SYS_CLK) begin
				if (SRST) begin
					in_reg[ch] <= ddc_pkg::CODE_ZERO;
					dac_reg[ch] <= ddc_pkg::CODE_ZERO;
					pm_reg[ch] <= ddc_pkg::PM_NORMAL;
					wake_cnt_reg[ch] <= 32'h0000_0000;
				end else if (por_pend | do_rst) begin
					// load reset code and hold it
					in_reg[ch] <= por_code;
					dac_reg[ch] <= por_code;
					pm_reg[ch] <= ddc_pkg::PM_NORMAL;
					wake_cnt_reg[ch] <= 32'h0000_0000;
				end else if (clr_go) begin
					in_reg[ch] <= cc_dec(cc_reg);
					dac_reg[ch] <= cc_dec(cc_reg);
				end else begin
					in_reg[ch] <= in_next;
					if (upd) dac_reg[ch] <= in_next;
					// new mode for selected channels only
					if (pm_hit) pm_reg[ch] <= pmode;
					// wake with load low takes input register
					if (waking & ~ld_low) dac_reg[ch] <= dac_reg[ch];
					else if (waking) dac_reg[ch] <= in_next;
					if (waking) wake_cnt_reg[ch] <= 32'(WAKE_CYCLES);
					else if (wake_cnt_reg[ch] != 32'h0000_0000)
						wake_cnt_reg[ch] <= wake_cnt_reg[ch] - 32'h0000_0001;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// output stage with model delays
	// ----------------------------------------
	// clear output delay timer
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			clr_cnt_reg <= 32'h0000_0000;
		end else if (clr_go) begin
			clr_cnt_reg <= 32'(CLR_CYCLES);
		end else if (clr_cnt_reg != 32'h0000_0000) begin
			clr_cnt_reg <= clr_cnt_reg - 32'h0000_0001;
		end
	end

	// trade-off: the clear timer freezes the codes, so writes in it show late
	// output codes follow dac registers once the clear timer lapses
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			out_reg[0] <= ddc_pkg::CODE_ZERO;
			out_reg[1] <= ddc_pkg::CODE_ZERO;
			vld_reg <= 2'h0;
			OUT_CODE_A <= ddc_pkg::CODE_ZERO;
			OUT_CODE_B <= ddc_pkg::CODE_ZERO;
			POWER_MODE_A <= ddc_pkg::PM_NORMAL;
			POWER_MODE_B <= ddc_pkg::PM_NORMAL;
			OUT_VALID_A <= 1'b0;
			OUT_VALID_B <= 1'b0;
			CHAIN_ENABLE <= 1'b0;
			CLEAR_ACTIVE <= 1'b0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				// hold old code during clear delay
				if (clr_cnt_reg == 32'h0000_0000) out_reg[i] <= dac_reg[i];
				// valid only when normal and awake
				vld_reg[i] <= (pm_reg[i] == ddc_pkg::PM_NORMAL) &&
					(wake_cnt_reg[i] == 32'h0000_0000);
			end
			// every port comes straight from a flop
			OUT_CODE_A <= out_reg[0];
			OUT_CODE_B <= out_reg[1];
			POWER_MODE_A <= pm_reg[0];
			POWER_MODE_B <= pm_reg[1];
			OUT_VALID_A <= vld_reg[0];
			OUT_VALID_B <= vld_reg[1];
			CHAIN_ENABLE <= chain_reg;
			CLEAR_ACTIVE <= clr_reg;
		end
	end
endmodule
`default_nettype wire

// ===== bench/ddc_checker.sv
// ddc_checker: port assertions for the dual dac command control.
// assumes one clock domain with SRST as its synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ddc_checker #(
	parameter int WAKE_CYCLES = 450,
	parameter int CLR_CYCLES = 1060
) (
	input wire logic SYS_CLK,
	input wire logic SRST,
	input wire logic FRAME_SEL_N,
	input wire logic RESET_LEVEL_SEL,
	input wire logic [15:0] OUT_CODE_A,
	input wire logic [15:0] OUT_CODE_B,
	input wire logic [1:0] POWER_MODE_A,
	input wire logic [1:0] POWER_MODE_B,
	input wire logic OUT_VALID_B,
	input wire logic CHAIN_ENABLE,
	input wire logic CLEAR_ACTIVE
);
	// slack for the syncs and output stages
	localparam int WAKE_MAX = WAKE_CYCLES + 20;
	localparam int CLR_MAX = CLR_CYCLES + 40;
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (SRST);
	// ----------------------------------------
	// helper: cycles in clear before the code shows
	// ----------------------------------------
	wire logic clr_shown = (OUT_CODE_A == OUT_CODE_B)
		&& (OUT_CODE_A inside {16'h0000, 16'h8000, 16'hFFFF});
	logic [11:0] clr_wait_reg;
	wire logic [11:0] clr_wait_next = (CLEAR_ACTIVE && !clr_shown) ? clr_wait_reg + 12'h001 : 12'h000;
	// a counter, since the clear delay can pass the range limit
	always_ff @(posedge SYS_CLK) begin
		clr_wait_reg <= SRST ? 12'h000 : clr_wait_next;
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	sequence s_pd_enter;
		(POWER_MODE_B == 2'h0) ##1 (POWER_MODE_B != 2'h0);
	endsequence
	sequence s_pd_leave;
		(POWER_MODE_B != 2'h0) ##1 (POWER_MODE_B == 2'h0);
	endsequence
	property p_reset_level;
		$fell(SRST) |-> ##[1:10] (OUT_CODE_A == (RESET_LEVEL_SEL ? 16'h8000 : 16'h0000));
	endproperty
	a_reset_level: assert property (p_reset_level) else $error("reset code missing");
	property p_pd_invalid;
		(POWER_MODE_B != 2'h0) [*3] |-> !OUT_VALID_B;
	endproperty
	a_pd_invalid: assert property (p_pd_invalid) else $error("valid in power-down");
	property p_wake;
		s_pd_leave |-> !OUT_VALID_B [*3] ##[1:WAKE_MAX] OUT_VALID_B;
	endproperty
	a_wake: assert property (p_wake) else $error("wake timing wrong");
	property p_pd_keep;
		s_pd_enter |-> $stable(OUT_CODE_B) [*4];
	endproperty
	a_pd_keep: assert property (p_pd_keep) else $error("code moved in power-down");
	property p_clr_load;
		clr_wait_reg <= CLR_MAX;
	endproperty
	a_clr_load: assert property (p_clr_load) else $error("clear code not shown");
	property p_clr_exit;
		$fell(CLEAR_ACTIVE) |-> !$past(FRAME_SEL_N, 10);
	endproperty
	a_clr_exit: assert property (p_clr_exit) else $error("clear left outside frame");
	property p_chain_frame;
		$changed(CHAIN_ENABLE) |-> !$past(FRAME_SEL_N, 10);
	endproperty
	a_chain_frame: assert property (p_chain_frame) else $error("chain moved outside frame");
	property p_mode_frame;
		$changed(POWER_MODE_A) || $changed(POWER_MODE_B) |-> !$past(FRAME_SEL_N, 10);
	endproperty
	a_mode_frame: assert property (p_mode_frame) else $error("mode moved outside frame");
endmodule
bind ddc_top ddc_checker #(.WAKE_CYCLES(WAKE_CYCLES), .CLR_CYCLES(CLR_CYCLES)) u_chk (
	.SYS_CLK(SYS_CLK), .SRST(SRST), .FRAME_SEL_N(FRAME_SEL_N),
	.RESET_LEVEL_SEL(RESET_LEVEL_SEL), .OUT_CODE_A(OUT_CODE_A), .OUT_CODE_B(OUT_CODE_B),
	.POWER_MODE_A(POWER_MODE_A), .POWER_MODE_B(POWER_MODE_B), .OUT_VALID_B(OUT_VALID_B),
	.CHAIN_ENABLE(CHAIN_ENABLE), .CLEAR_ACTIVE(CLEAR_ACTIVE));
`default_nettype wire

// ===== bench/ddc_host_model.sv
// ddc_host_model: host serial port sending command frames.
// assumes the device shifts on falling serial clock edges.
`timescale 1ns/1ps
`default_nettype none
module ddc_host_model (
	output var logic sclk,
	output var logic fs_n,
	output var logic sdata
);
	localparam int HALF = 80;
	// idle: clock parked high between frames
	initial begin
		sclk = 1'b1;
		fs_n = 1'b1;
		sdata = 1'b0;
	end
	// msb first, one bit per fall
	task automatic send(input logic [31:0] w, input int n);
		fs_n = 1'b0;
		for (int i = 31; i > 31 - n; i--) begin
			sdata = w[i];
			#HALF sclk = 1'b0;
			if (i > 32 - n) #HALF sclk = 1'b1;
		end
		// released line shows the inverse, never a stale bit
		#20 fs_n = 1'b1;
		sdata = ~sdata;
		#HALF sclk = 1'b1;
		#1900;
	endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// testbench: host model feeds frames into ddc_top; outputs checked.
// assumes wake and clear counts cut to 5 cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0, srst = 1'b1, ld_n = 1'b1, clr_n = 1'b1, lvl = 1'b1;
	logic [15:0] oa, ob, ea, eb, r;
	logic [1:0] pa, pb, ma, mb;
	logic va, vb, ch, ca, ec, ek;
	logic [19:0] p;
	wire logic sclk, fs_n, sd;
	logic [39:0] exp_q[$];
	int err_count = 0, comparisons = 0;
	event seen_ev;
	wire logic [39:0] obs = {oa, ob, pa, pb, va, vb, ch, ca};
	localparam logic [15:0] CLR_TAB [3] = '{ddc_pkg::CODE_ZERO, ddc_pkg::CODE_MID,
		ddc_pkg::CODE_FULL};
	ddc_host_model host (.sclk(sclk), .fs_n(fs_n), .sdata(sd));
	ddc_top #(.WAKE_CYCLES(5), .CLR_CYCLES(5)) dut (.SYS_CLK(clk), .SRST(srst),
		.SERIAL_CLK(sclk), .FRAME_SEL_N(fs_n), .SERIAL_DATA(sd), .LOAD_UPDATE_PIN_N(ld_n),
		.ASYNC_CLEAR_INPUT_N(clr_n), .RESET_LEVEL_SEL(lvl), .OUT_CODE_A(oa), .OUT_CODE_B(ob),
		.POWER_MODE_A(pa), .POWER_MODE_B(pb), .OUT_VALID_A(va), .OUT_VALID_B(vb),
		.CHAIN_ENABLE(ch), .CLEAR_ACTIVE(ca));
	initial forever #5 clk = ~clk;
	task automatic check(input logic [39:0] seen, input logic [39:0] want);
		comparisons++;
		if (seen !== want) begin
			err_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// note the expected state, wait bounded for it, then wake the monitor
	task automatic expect_state();
		logic [39:0] want;
		want = {ea, eb, ma, mb, ma == 2'h0, mb == 2'h0, ec, ek};
		exp_q.push_back(want);
		for (int i = 0; i < 300 && obs !== want; i++) @(posedge clk);
		#1 -> seen_ev;
		#1 if (obs !== want) finish_test();
	endtask
	// monitor takes the oldest note when a result is announced
	always @(seen_ev) check(obs, exp_q.pop_front());
	task automatic wr(input logic [3:0] c, input logic [3:0] a, input int n = 32);
		r = 16'($urandom);
		host.send({4'($urandom), c, a, r, 4'($urandom)}, n);
	endtask
	task automatic ctl(input logic [3:0] c);
		host.send({4'($urandom), c, ddc_pkg::ADR_BOTH, p}, 32);
	endtask
	// 8 cycles low so the pin syncs agree on the edge
	task automatic pulse(ref logic pin);
		@(posedge clk);
		#1 pin = 1'b0;
		repeat (8) @(posedge clk);
		#1 pin = 1'b1;
	endtask
	initial begin
		void'($urandom(99));
		{ea, eb, ma, mb, ec, ek} = {ddc_pkg::CODE_MID, ddc_pkg::CODE_MID, 6'h00};
		repeat (16) @(posedge clk);
		#1 srst = 1'b0;
		expect_state();
		wr(ddc_pkg::CMD_WR_UPD, ddc_pkg::ADR_A);
		ea = r;
		expect_state();
		wr(ddc_pkg::CMD_WR_IN, ddc_pkg::ADR_B);
		expect_state();
		pulse(ld_n);
		eb = r;
		expect_state();
		wr(ddc_pkg::CMD_WR_IN, ddc_pkg::ADR_BOTH);
		expect_state();
		{ea, eb} = {r, r};
		wr(ddc_pkg::CMD_UPD, ddc_pkg::ADR_BOTH);
		expect_state();
		// cut frame, reserved address, reserved command
		wr(ddc_pkg::CMD_WR_UPD, ddc_pkg::ADR_B, 20);
		wr(ddc_pkg::CMD_WR_UPD, 4'h1);
		wr(4'h9, ddc_pkg::ADR_A);
		expect_state();
		wr(ddc_pkg::CMD_WR_IN, ddc_pkg::ADR_B);
		eb = r;
		wr(ddc_pkg::CMD_WR_UPD_ALL, ddc_pkg::ADR_A);
		ea = r;
		expect_state();
		p = 20'h00001;
		ctl(ddc_pkg::CMD_OVR);
		wr(ddc_pkg::CMD_WR_IN, ddc_pkg::ADR_A);
		ea = r;
		wr(ddc_pkg::CMD_WR_IN, ddc_pkg::ADR_B);
		expect_state();
		// load held low only while standalone
		@(posedge clk);
		#1 ld_n = 1'b0;
		wr(ddc_pkg::CMD_WR_IN, ddc_pkg::ADR_B);
		eb = r;
		expect_state();
		#1 ld_n = 1'b1;
		for (int m = 1; m < 5; m++) begin
			if (m == 4) wr(ddc_pkg::CMD_WR_IN, ddc_pkg::ADR_B);
			p = 20'($urandom);
			{p[9:8], p[3], p[0]} = {2'(m % 4), 2'b10};
			ctl(ddc_pkg::CMD_PWR);
			mb = 2'(m % 4);
			expect_state();
		end
		for (int c = 1; c >= 0; c--) begin
			p = 20'($urandom);
			p[1] = c[0];
			ctl(ddc_pkg::CMD_CHAIN);
			ec = c[0];
			expect_state();
		end
		// each clear code, clear landing in mid-frame for codes 0 to 2
		for (int k = 0; k < 4; k++) begin
			p = 20'($urandom);
			p[1:0] = 2'(k);
			ctl(ddc_pkg::CMD_CCODE);
			ek = 1'b0;
			expect_state();
			fork
				if (k < 3) wr(ddc_pkg::CMD_WR_UPD, ddc_pkg::ADR_A);
				begin
					repeat (100) @(posedge clk);
					pulse(clr_n);
				end
			join
			if (k < 3) {ea, eb, ek} = {CLR_TAB[k], CLR_TAB[k], 1'b1};
			expect_state();
		end
		#1 lvl = 1'b0;
		p = 20'($urandom);
		ctl(ddc_pkg::CMD_RESET);
		{ea, eb} = {ddc_pkg::CODE_ZERO, ddc_pkg::CODE_ZERO};
		expect_state();
		finish_test();
	end
endmodule
`default_nettype wire
